/* File: dv/sdc_conv_model.sv */
// Purpose: measurement engine and page-two word source facing the decoder
// Assumes: one conversion at a time, words fed one per cycle while walked
// Notes: slow_i stretches each conversion by a random delay
`timescale 1ns/1ps
module sdc_conv_model (
	// clock
	input wire logic clk_i,
	// conversion handshake
	input wire logic conv_req_i,
	input wire logic slow_i,
	output logic conv_done_o,
	// page two word feed
	input wire logic cfg_walk_i,
	input wire logic corrupt_i,
	output logic [13:0] cfg_word_o,
	output logic cfg_last_o
);
	import sdc_pkg::*;
	localparam int NW = 6;
	int k = 0;
	initial begin
		conv_done_o = 1'b0;
		cfg_word_o = 14'h2a5a;
		cfg_last_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// answer each conversion, promptly or late
	always @(posedge clk_i) begin
		if (conv_req_i === 1'b1) begin
			repeat (slow_i ? 2 + ($urandom % 7) : 0) @(negedge clk_i);
			@(negedge clk_i);
			conv_done_o = 1'b1;
			@(negedge clk_i);
			conv_done_o = 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// outside a walk the word bus keeps changing
	always @(negedge clk_i) begin
		if (cfg_walk_i) begin
			cfg_word_o = 14'(14'h0123 * (k + 1)) ^ ((corrupt_i && k == 2) ? 14'h0010 : 14'h0000);
			cfg_last_o = (k == NW - 1);
			k = (k == NW - 1) ? 0 : k + 1;
		end else begin
			cfg_word_o = ~cfg_word_o;
			cfg_last_o = 1'b0;
			k = 0;
		end
	end
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the command decoder
// Assumes: single device, own address 4'h3, inputs driven on falling edges
// Notes: random reads mixed with fixed corner cases
`timescale 1ns/1ps
module testbench;
	import sdc_pkg::*;
	localparam int NO = -1, A = 0, N = 1, D = 2, F = 3, ANY = 4, DK = 5;
	logic clk_i = 0, sys_rst_i = 1, link_clk_i = 0, link_rst_i = 1;
	logic req_i = 0, req_wr_i = 0, stand_alone_i = 1, bottom_i = 1, top_i = 1;
	logic [2:0] req_page_i = 0;
	logic [5:0] req_addr_i = 0;
	logic [3:0] req_dev_i = 0, own_addr_i = 4'h3;
	logic rsp_valid_o, conv_req_o, conv_done_i, scan_cont_o, balance_global_enable_o;
	logic register_checksum_fault_o, sleep_o, ident_o, regs_reload_o, wake_clk_o, cfg_walk_o, cfg_last_i;
	logic [1:0] rsp_kind_o;
	logic [2:0] conv_kind_o;
	logic [3:0] conv_index_o;
	logic [13:0] rsp_data_o, cfg_word_i, nv_word_i = 0, rc3 = 0, rc2 = 0, rc1 = 0, nvsig = 0, s1;
	logic nv_valid_i = 0, nv_last_i = 0, link_wake_i = 0, link_noack_i = 0, slow = 0, corrupt = 0;
	logic [11:0] flags = 0;
	logic rgot, wake_prev = 0, seen_ident = 0, seen_reload = 0, seen_fail = 0;
	logic [1:0] rkind;
	logic [13:0] rdata;
	logic [6:0] conv_log[$];
	int err_count = 0, n_tests = 0, cycles = 0, wake_edges = 0;
	logic [13:0] nvw[4] = '{14'h1234, 14'h0abc, 14'h3001, 14'h2222};

	sdc_decoder #(.NCELL(SDC_NCELL)) sdc_decoder_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
		.req_wr_i(req_wr_i), .req_page_i(req_page_i), .req_addr_i(req_addr_i), .req_dev_i(req_dev_i),
		.own_addr_i(own_addr_i), .stand_alone_i(stand_alone_i), .bottom_i(bottom_i), .top_i(top_i),
		.rsp_valid_o(rsp_valid_o), .rsp_kind_o(rsp_kind_o), .rsp_data_o(rsp_data_o), .conv_req_o(conv_req_o),
		.conv_kind_o(conv_kind_o), .conv_index_o(conv_index_o), .conv_done_i(conv_done_i),
		.scan_cont_o(scan_cont_o), .balance_global_enable_o(balance_global_enable_o),
		.register_checksum_fault_o(register_checksum_fault_o), .sleep_o(sleep_o), .ident_o(ident_o),
		.regs_reload_o(regs_reload_o), .wake_clk_o(wake_clk_o), .cfg_word_i(cfg_word_i), .cfg_last_i(cfg_last_i),
		.cfg_walk_o(cfg_walk_o), .ref_coeff_third_i(rc3), .ref_coeff_second_i(rc2), .ref_coeff_first_i(rc1),
		.nv_signature_register_i(nvsig), .nv_word_i(nv_word_i), .nv_valid_i(nv_valid_i), .nv_last_i(nv_last_i),
		.cell_balance_active_flag_i(flags), .link_clk_i(link_clk_i), .link_rst_i(link_rst_i),
		.link_wake_i(link_wake_i), .link_noack_i(link_noack_i));
	sdc_conv_model sdc_conv_model_inst (.clk_i(clk_i), .conv_req_i(conv_req_o), .slow_i(slow),
		.conv_done_o(conv_done_i), .cfg_walk_i(cfg_walk_o), .corrupt_i(corrupt), .cfg_word_o(cfg_word_i),
		.cfg_last_o(cfg_last_i));

	initial forever #2.5 clk_i = ~clk_i;
	initial begin
		#7.3;
		forever #16 link_clk_i = ~link_clk_i;
	end
	////////////////////////////////////////////////////////////////
	// monitors and hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (!sys_rst_i && conv_req_o === 1'b1) conv_log.push_back({conv_kind_o, conv_index_o});
		if (wake_clk_o !== wake_prev) wake_edges++;
		wake_prev = wake_clk_o;
		if (ident_o === 1'b1) seen_ident = 1;
		if (regs_reload_o === 1'b1) seen_reload = 1;
		if (rsp_valid_o === 1'b1 && rsp_kind_o === 2'(SDC_RSP_FAIL)) seen_fail = 1;
		if (cycles == 60000) begin
			err_count++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic ask(input logic wr, input logic [2:0] pg, input logic [5:0] ad, input logic [3:0] dv,
		input int ek, input logic [13:0] ed);
		int lim;
		lim = (pg == SDC_PAGE_CMD && ad == SDC_CMD_WAKE) ? 200 : 40;
		rgot = 0;
		@(negedge clk_i);
		req_i = 1; req_wr_i = wr; req_page_i = pg; req_addr_i = ad; req_dev_i = dv;
		@(negedge clk_i);
		req_i = 0; req_wr_i = ~wr; req_addr_i = ~ad;
		for (int i = 0; i < lim && !rgot; i++) begin
			if (rsp_valid_o === 1'b1) begin
				rgot = 1; rkind = rsp_kind_o; rdata = rsp_data_o;
			end else @(negedge clk_i);
		end
		if (ek != ANY) chk("answered", 16'(rgot), 16'(ek != NO));
		if (ek >= 0 && ek != ANY && rgot) chk("kind", 16'(rkind), 16'(ek == DK ? D : ek));
		if (ek == D && rgot) chk("data", 16'(rdata), 16'(ed));
	endtask
	task automatic cmd(input logic [5:0] c, input int ek);
		ask(1'b0, SDC_PAGE_CMD, c, own_addr_i, ek, 14'h0);
	endtask
	function automatic void exp_conv(input logic [5:0] c, ref logic [6:0] e[$]);
		if (c == SDC_CMD_SCAN_V || c == SDC_CMD_SCAN_ALL || c == SDC_CMD_SCAN_MIX) begin
			e.push_back({SDC_CONV_PACK, 4'h0});
			for (int i = 0; i < SDC_NCELL; i++) begin
				e.push_back({SDC_CONV_CELL, 4'(i)});
				if (c == SDC_CMD_SCAN_MIX && i == 5) e.push_back({SDC_CONV_EXT, 4'h0});
			end
		end
		if (c == SDC_CMD_SCAN_T || c == SDC_CMD_SCAN_ALL) begin
			for (int i = 0; i < SDC_EXT_N; i++) e.push_back({SDC_CONV_EXT, 4'(i)});
			e.push_back({SDC_CONV_DIE, 4'h0});
			e.push_back({SDC_CONV_REF, 4'h0});
		end
		if (c == SDC_CMD_SCAN_W || c == SDC_CMD_SCAN_ALL) e.push_back({SDC_CONV_WIRE, 4'h0});
		if (c == SDC_CMD_MEASURE) e.push_back({SDC_CONV_TARGET, 4'h0});
	endfunction
	task automatic run_scan(input logic [5:0] c);
		logic [6:0] e[$];
		logic [6:0] m;
		exp_conv(c, e);
		conv_log = {};
		slow = 1'($urandom % 2);
		cmd(c, A);
		for (int i = 0; i < 3000 && conv_log.size() < e.size(); i++) @(negedge clk_i);
		repeat (20) @(negedge clk_i);
		chk("conversion count", 16'(conv_log.size()), 16'(e.size()));
		foreach (e[i]) if (i < conv_log.size()) begin
			m = (e[i][6:4] == SDC_CONV_CELL || e[i][6:4] == SDC_CONV_EXT) ? 7'h7f : 7'h70;
			chk("conversion", 16'(conv_log[i] & m), 16'(e[i] & m));
		end
	endtask
	task automatic nv_load();
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			nv_valid_i = 1; nv_word_i = nvw[i]; nv_last_i = (i == 3);
		end
		@(negedge clk_i);
		nv_valid_i = 0; nv_last_i = 0; nv_word_i = ~nv_word_i;
	endtask
	task automatic walk(input logic [5:0] c);
		cmd(c, ANY);
		repeat (3) @(negedge clk_i);
		for (int i = 0; i < 100 && cfg_walk_o !== 1'b0; i++) @(negedge clk_i);
		repeat (3) @(negedge clk_i);
	endtask
	task automatic link_pulse(input logic w);
		@(negedge link_clk_i);
		if (w) link_wake_i = 1;
		else link_noack_i = 1;
		repeat (3) @(negedge link_clk_i);
		link_wake_i = 0; link_noack_i = 0;
		repeat (20) @(negedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [5:0] a;
		logic [5:0] scans[6] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08};
		void'($urandom(32'hb47d411f));
		repeat (20) @(negedge clk_i);
		sys_rst_i = 0; link_rst_i = 0;
		nv_load();
		ask(1'b0, SDC_PAGE_NVS, SDC_OFS_NVS, own_addr_i, DK, 14'h0);
		s1 = rdata;
		nvsig = 14'($urandom);
		ask(1'b0, SDC_PAGE_NVF, SDC_OFS_NVF, own_addr_i, D, nvsig);
		cmd(SDC_CMD_ACK, A);
		ask(1'b0, SDC_PAGE_CMD, SDC_CMD_ACK, own_addr_i ^ 4'h1, NO, 14'h0);
		foreach (scans[i]) run_scan(scans[i]);
		cmd(SDC_CMD_SCAN_CONT, ANY);
		chk("scan flag", 16'(scan_cont_o), 16'h1);
		cmd(SDC_CMD_SCAN_INH, ANY);
		chk("scan flag", 16'(scan_cont_o), 16'h0);
		ask(1'b0, SDC_PAGE_CMD, SDC_CMD_BAL_EN, SDC_ADDR_ALL, ANY, 14'h0);
		chk("balance enable", 16'(balance_global_enable_o), 16'h1);
		ask(1'b0, SDC_PAGE_CMD, SDC_CMD_BAL_INH, SDC_ADDR_ALL, ANY, 14'h0);
		chk("balance enable", 16'(balance_global_enable_o), 16'h0);
		cmd(SDC_CMD_IDENT, ANY);
		@(negedge clk_i);
		chk("identify pulse", 16'(seen_ident), 16'h1);
		foreach (scans[i]) ask(1'b1, SDC_PAGE_CMD, scans[i], own_addr_i, N, 14'h0);
		cmd(6'h0d, N);
		cmd(6'h00, N);
		cmd(6'h15, N);
		walk(SDC_CMD_CALC_CK);
		walk(SDC_CMD_CHECK_CK);
		chk("checksum fault", 16'(register_checksum_fault_o), 16'h0);
		corrupt = 1;
		walk(SDC_CMD_CHECK_CK);
		chk("checksum fault", 16'(register_checksum_fault_o), 16'h1);
		corrupt = 0;
		cmd(SDC_CMD_SCAN_CONT, ANY);
		cmd(SDC_CMD_BAL_EN, ANY);
		cmd(SDC_CMD_RESET, ANY);
		@(negedge clk_i);
		chk("reload pulse", 16'(seen_reload), 16'h1);
		chk("stopped", 16'({scan_cont_o, balance_global_enable_o, register_checksum_fault_o}), 16'h0);
		nv_load();
		ask(1'b0, SDC_PAGE_NVS, SDC_OFS_NVS, own_addr_i, D, s1);
		cmd(SDC_CMD_IDENT, ANY);
		for (int i = 0; i < 24; i++) begin
			rc3 = 14'($urandom); rc2 = 14'($urandom); rc1 = 14'($urandom);
			flags = 12'($urandom);
			stand_alone_i = (i < 2) ? 1'(i) : 1'($urandom % 2);
			a = 6'(6'h15 + $urandom % 43);
			case ($urandom % 5)
				0: ask(1'b0, SDC_PAGE_CFG, SDC_OFS_REF_C, own_addr_i, D, rc3);
				1: ask(1'b0, SDC_PAGE_CFG, SDC_OFS_REF_B, own_addr_i, D, rc2);
				2: ask(1'b0, SDC_PAGE_CFG, SDC_OFS_REF_A, own_addr_i, D, rc1);
				3: ask(1'b0, 3'h7, a, own_addr_i, N, 14'h0);
				default: ask(1'b0, SDC_PAGE_CMD, a, own_addr_i, N, 14'h0);
			endcase
			ask(1'b0, SDC_PAGE_CFG, SDC_OFS_BAL, own_addr_i, stand_alone_i ? D : N, {2'h0, flags});
		end
		stand_alone_i = 1;
		link_pulse(1'b0);
		chk("comms failure", 16'(seen_fail), 16'h1);
		wake_edges = 0;
		cmd(SDC_CMD_WAKE, A);
		@(negedge clk_i);
		chk("wake clock edges", 16'(wake_edges), 16'(SDC_WAKE_EDGES));
		cmd(SDC_CMD_SLEEP, ANY);
		chk("asleep", 16'(sleep_o), 16'h1);
		cmd(SDC_CMD_ACK, NO);
		link_pulse(1'b1);
		chk("asleep", 16'(sleep_o), 16'h0);
		cmd(SDC_CMD_ACK, A);
		conclude();
	end
endmodule

/* File: rtl/sdc_decoder.sv */
// Purpose: decode device commands and answer register reads
// Assumes: request strobe from the frame decoder on clk_i; link events on link_clk_i
// Notes: scan order driven through conv_req_o / conv_done_i handshake
`timescale 1ns/1ps
module sdc_decoder #(
	parameter int NCELL = 12
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// request from frame decoder
	input wire logic req_i,
	input wire logic req_wr_i,
	input wire logic [sdc_pkg::SDC_PW-1:0] req_page_i,
	input wire logic [sdc_pkg::SDC_AW-1:0] req_addr_i,
	input wire logic [3:0] req_dev_i,
	input wire logic [3:0] own_addr_i,
	input wire logic stand_alone_i,
	input wire logic bottom_i,
	input wire logic top_i,
	// answer
	output logic rsp_valid_o,
	output logic [1:0] rsp_kind_o,
	output logic [sdc_pkg::SDC_DW-1:0] rsp_data_o,
	// measurement engine
	output logic conv_req_o,
	output logic [2:0] conv_kind_o,
	output logic [3:0] conv_index_o,
	input wire logic conv_done_i,
	// state toward the device
	output logic scan_cont_o,
	output logic balance_global_enable_o,
	output logic register_checksum_fault_o,
	output logic sleep_o,
	output logic ident_o,
	output logic regs_reload_o,
	output logic wake_clk_o,
	// page two contents and nonvolatile values
	input wire logic [sdc_pkg::SDC_DW-1:0] cfg_word_i,
	input wire logic cfg_last_i,
	output logic cfg_walk_o,
	input wire logic [sdc_pkg::SDC_DW-1:0] ref_coeff_third_i,
	input wire logic [sdc_pkg::SDC_DW-1:0] ref_coeff_second_i,
	input wire logic [sdc_pkg::SDC_DW-1:0] ref_coeff_first_i,
	input wire logic [sdc_pkg::SDC_DW-1:0] nv_signature_register_i,
	input wire logic [sdc_pkg::SDC_DW-1:0] nv_word_i,
	input wire logic nv_valid_i,
	input wire logic nv_last_i,
	input wire logic [NCELL-1:0] cell_balance_active_flag_i,
	// link domain
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	input wire logic link_wake_i,
	input wire logic link_noack_i
);
	import sdc_pkg::*;

	typedef enum {SDC_IDLE, SDC_CONV, SDC_WAIT, SDC_CKSUM, SDC_WAKE} sdc_state_t;
	typedef enum {SDC_SEQ_V, SDC_SEQ_T, SDC_SEQ_MIX, SDC_SEQ_W, SDC_SEQ_ONE} sdc_seq_t;

	typedef struct packed {
		sdc_state_t st;
		sdc_seq_t seq;
		logic all;
		logic [2:0] kind;
		logic [3:0] idx;
		logic rv;
		logic [1:0] rk;
		logic [13:0] rd;
		logic creq;
		logic cont;
		logic balance_global_enable;
		logic par;
		logic slp;
		logic ident;
		logic reload;
		logic check;
		logic [13:0] sum;
		logic [13:0] held;
		logic [13:0] shadow;
		logic [NCELL-1:0] bal;
		logic [5:0] wcnt;
		logic [3:0] wedge;
		logic wclk;
		logic walk;
		logic [2:0] wk_s;
		logic [2:0] na_s;
	} sdc_core_t;

	sdc_core_t c_reg, c_next;

	////////////////////////////////////////////////////////////////////
	// link domain: wake and no-ack events held as toggles
	logic wake_tgl_reg, noack_tgl_reg, wake_d_reg, noack_d_reg;
	always_ff @(posedge link_clk_i) begin
		if (link_rst_i) begin
			wake_tgl_reg <= 1'b0;
			noack_tgl_reg <= 1'b0;
			wake_d_reg <= 1'b0;
			noack_d_reg <= 1'b0;
		end else begin
			wake_d_reg <= link_wake_i;
			noack_d_reg <= link_noack_i;
			if (link_wake_i && !wake_d_reg)
				wake_tgl_reg <= ~wake_tgl_reg;
			if (link_noack_i && !noack_d_reg)
				noack_tgl_reg <= ~noack_tgl_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// request decode helpers
	logic for_me, cmd_hit, wake_evt, noack_evt;
	logic [13:0] msir_step;
	assign for_me = (req_dev_i == own_addr_i) || (req_dev_i == SDC_ADDR_ALL);
	assign wake_evt = c_reg.wk_s[2] ^ c_reg.wk_s[1];
	assign noack_evt = c_reg.na_s[2] ^ c_reg.na_s[1];
	always_comb begin
		case (req_addr_i)
			SDC_CMD_SCAN_V, SDC_CMD_SCAN_T, SDC_CMD_SCAN_MIX, SDC_CMD_SCAN_W, SDC_CMD_SCAN_ALL,
			SDC_CMD_SCAN_CONT, SDC_CMD_SCAN_INH, SDC_CMD_MEASURE, SDC_CMD_IDENT, SDC_CMD_SLEEP,
			SDC_CMD_ACK, SDC_CMD_WAKE, SDC_CMD_BAL_EN, SDC_CMD_BAL_INH, SDC_CMD_RESET,
			SDC_CMD_CALC_CK, SDC_CMD_CHECK_CK: cmd_hit = 1'b1;
			default: cmd_hit = 1'b0;
		endcase
	end

	function automatic logic [13:0] sdc_nv_checksum_factory(input logic [13:0] s, input logic [13:0] d);
		sdc_nv_checksum_factory = {s[12:0], s[13] ^ s[4] ^ s[2] ^ s[0]} ^ d;
	endfunction
	assign msir_step = sdc_nv_checksum_factory(c_reg.sum, cfg_word_i);

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		c_next = c_reg;
		c_next.rv = 1'b0;
		c_next.creq = 1'b0;
		c_next.ident = 1'b0;
		c_next.reload = 1'b0;
		c_next.wk_s = {c_reg.wk_s[1:0], wake_tgl_reg};
		c_next.na_s = {c_reg.na_s[1:0], noack_tgl_reg};
		c_next.bal = cell_balance_active_flag_i;
		if (nv_valid_i)
			c_next.shadow = sdc_nv_checksum_factory(c_reg.shadow, nv_word_i);
		if (noack_evt) begin
			c_next.rv = 1'b1;
			c_next.rk = SDC_RSP_FAIL;
		end
		if (c_reg.slp && wake_evt)
			c_next.slp = 1'b0;
		case (c_reg.st)
			SDC_IDLE: begin
				if (req_i && for_me && !c_reg.slp) begin
					c_next.rv = 1'b1;
					c_next.rk = SDC_RSP_ACK;
					c_next.rd = SDC_RST_WORD;
					if (req_page_i == SDC_PAGE_CMD) begin
						if (req_wr_i || !cmd_hit)
							c_next.rk = SDC_RSP_NAK;
						else begin
							case (req_addr_i)
								SDC_CMD_SCAN_V: begin
									c_next.seq = SDC_SEQ_V;
									c_next.all = 1'b0;
									c_next.kind = SDC_CONV_PACK;
									c_next.idx = 4'h0;
									c_next.st = SDC_CONV;
								end
								SDC_CMD_SCAN_T: begin
									c_next.seq = SDC_SEQ_T;
									c_next.all = 1'b0;
									c_next.kind = SDC_CONV_EXT;
									c_next.idx = 4'h0;
									c_next.st = SDC_CONV;
								end
								SDC_CMD_SCAN_MIX: begin
									c_next.seq = SDC_SEQ_MIX;
									c_next.all = 1'b0;
									c_next.kind = SDC_CONV_PACK;
									c_next.idx = 4'h0;
									c_next.st = SDC_CONV;
								end
								SDC_CMD_SCAN_W: begin
									c_next.seq = SDC_SEQ_W;
									c_next.all = 1'b0;
									c_next.kind = SDC_CONV_WIRE;
									c_next.idx = 4'h0;
									c_next.st = SDC_CONV;
								end
								SDC_CMD_SCAN_ALL: begin
									c_next.seq = SDC_SEQ_V;
									c_next.all = 1'b1;
									c_next.kind = SDC_CONV_PACK;
									c_next.idx = 4'h0;
									c_next.st = SDC_CONV;
								end
								SDC_CMD_MEASURE: begin
									c_next.seq = SDC_SEQ_ONE;
									c_next.all = 1'b0;
									c_next.kind = SDC_CONV_TARGET;
									c_next.idx = 4'h0;
									c_next.st = SDC_CONV;
								end
								SDC_CMD_SCAN_CONT: c_next.cont = 1'b1;
								SDC_CMD_SCAN_INH: c_next.cont = 1'b0;
								SDC_CMD_IDENT: c_next.ident = 1'b1;
								SDC_CMD_SLEEP: c_next.slp = 1'b1;
								SDC_CMD_BAL_EN: c_next.balance_global_enable = 1'b1;
								SDC_CMD_BAL_INH: c_next.balance_global_enable = 1'b0;
								SDC_CMD_RESET: begin
									c_next.reload = 1'b1;
									c_next.cont = 1'b0;
									c_next.balance_global_enable = 1'b0;
									c_next.par = 1'b0;
									c_next.shadow = SDC_RST_WORD;
								end
								SDC_CMD_CALC_CK: begin
									c_next.check = 1'b0;
									c_next.sum = SDC_RST_WORD;
									c_next.walk = 1'b1;
									c_next.st = SDC_CKSUM;
								end
								SDC_CMD_CHECK_CK: begin
									c_next.check = 1'b1;
									c_next.sum = SDC_RST_WORD;
									c_next.walk = 1'b1;
									c_next.st = SDC_CKSUM;
								end
								SDC_CMD_WAKE: begin
									if (bottom_i) begin
										c_next.rv = 1'b0;
										c_next.wedge = 4'h0;
										c_next.wcnt = 6'h0;
										c_next.st = SDC_WAKE;
									end
								end
								default: ;
							endcase
						end
					end else begin
						c_next.rk = SDC_RSP_DATA;
						if (req_wr_i)
							c_next.rk = SDC_RSP_NAK;
						else if (req_page_i == SDC_PAGE_CFG && req_addr_i == SDC_OFS_REF_C)
							c_next.rd = ref_coeff_third_i;
						else if (req_page_i == SDC_PAGE_CFG && req_addr_i == SDC_OFS_REF_B)
							c_next.rd = ref_coeff_second_i;
						else if (req_page_i == SDC_PAGE_CFG && req_addr_i == SDC_OFS_REF_A)
							c_next.rd = ref_coeff_first_i;
						else if (req_page_i == SDC_PAGE_CFG && req_addr_i == SDC_OFS_BAL) begin
							if (stand_alone_i)
								c_next.rd = 14'(c_reg.bal);
							else
								c_next.rk = SDC_RSP_NAK;
						end else if (req_page_i == SDC_PAGE_NVF && req_addr_i == SDC_OFS_NVF)
							c_next.rd = nv_signature_register_i;
						else if (req_page_i == SDC_PAGE_NVS && req_addr_i == SDC_OFS_NVS)
							c_next.rd = c_reg.shadow;
						else
							c_next.rk = SDC_RSP_NAK;
					end
				end
			end
			SDC_CONV: begin
				c_next.creq = 1'b1;
				c_next.st = SDC_WAIT;
			end
			SDC_WAIT: begin
				if (conv_done_i) begin
					c_next.st = SDC_CONV;
					case (c_reg.seq)
						SDC_SEQ_V, SDC_SEQ_MIX: begin
							if (c_reg.kind == SDC_CONV_PACK) begin
								c_next.kind = SDC_CONV_CELL;
								c_next.idx = 4'h0;
							end else if (c_reg.seq == SDC_SEQ_MIX && c_reg.kind == SDC_CONV_CELL
								&& c_reg.idx == SDC_MIX_EXT_AFTER - 4'h1) begin
								c_next.kind = SDC_CONV_EXT;
								c_next.idx = 4'h0;
							end else if (c_reg.kind == SDC_CONV_EXT) begin
								c_next.kind = SDC_CONV_CELL;
								c_next.idx = SDC_MIX_EXT_AFTER;
							end else if (c_reg.idx != 4'(NCELL - 1))
								c_next.idx = c_reg.idx + 4'h1;
							else if (c_reg.all) begin
								c_next.seq = SDC_SEQ_T;
								c_next.kind = SDC_CONV_EXT;
								c_next.idx = 4'h0;
							end else
								c_next.st = SDC_IDLE;
						end
						SDC_SEQ_T: begin
							if (c_reg.kind == SDC_CONV_EXT && c_reg.idx != 4'(SDC_EXT_N - 1))
								c_next.idx = c_reg.idx + 4'h1;
							else if (c_reg.kind == SDC_CONV_EXT) begin
								c_next.kind = SDC_CONV_DIE;
								c_next.idx = 4'h0;
							end else if (c_reg.kind == SDC_CONV_DIE)
								c_next.kind = SDC_CONV_REF;
							else if (c_reg.all) begin
								c_next.seq = SDC_SEQ_W;
								c_next.kind = SDC_CONV_WIRE;
							end else
								c_next.st = SDC_IDLE;
						end
						default: c_next.st = SDC_IDLE;
					endcase
				end
			end
			SDC_CKSUM: begin
				c_next.sum = msir_step;
				if (cfg_last_i) begin
					c_next.walk = 1'b0;
					c_next.st = SDC_IDLE;
					if (!c_reg.check)
						c_next.held = msir_step;
					else if (msir_step != c_reg.held)
						c_next.par = 1'b1;
				end
			end
			SDC_WAKE: begin
				c_next.wcnt = c_reg.wcnt + 6'h1;
				if (c_reg.wcnt == 6'(SDC_WAKE_HALF - 1)) begin
					c_next.wcnt = 6'h0;
					c_next.wclk = ~c_reg.wclk;
					c_next.wedge = c_reg.wedge + 4'h1;
					if (c_reg.wedge == 4'(SDC_WAKE_EDGES - 1)) begin
						c_next.wclk = 1'b0;
						c_next.st = SDC_IDLE;
						c_next.slp = 1'b0;
						c_next.rv = top_i;
						c_next.rk = SDC_RSP_ACK;
					end
				end
			end
			default: c_next.st = SDC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			c_reg <= '0;
			c_reg.st <= SDC_IDLE;
			c_reg.seq <= SDC_SEQ_V;
		end else
			c_reg <= c_next;
	end

	////////////////////////////////////////////////////////////////////
	assign rsp_valid_o = c_reg.rv;
	assign rsp_kind_o = c_reg.rk;
	assign rsp_data_o = c_reg.rd;
	assign conv_req_o = c_reg.creq;
	assign conv_kind_o = c_reg.kind;
	assign conv_index_o = c_reg.idx;
	assign scan_cont_o = c_reg.cont;
	assign balance_global_enable_o = c_reg.balance_global_enable;
	assign register_checksum_fault_o = c_reg.par;
	assign sleep_o = c_reg.slp;
	assign ident_o = c_reg.ident;
	assign regs_reload_o = c_reg.reload;
	assign wake_clk_o = c_reg.wclk;
	assign cfg_walk_o = c_reg.walk;

	////////////////////////////////////////////////////////////////////
	sequence s_cmd(logic [5:0] a);
		req_i && !req_wr_i && for_me && !c_reg.slp && c_reg.st == SDC_IDLE
			&& req_page_i == SDC_PAGE_CMD && req_addr_i == a;
	endsequence

	a_write_nak: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i && req_wr_i && for_me && !c_reg.slp && c_reg.st == SDC_IDLE && req_page_i == SDC_PAGE_CMD
		|=> rsp_valid_o && rsp_kind_o == SDC_RSP_NAK) else $error("write to command page not refused");
	a_gap_nak: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(6'h0d) |=> rsp_kind_o == SDC_RSP_NAK) else $error("undefined command not refused");
	a_scan_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(SDC_CMD_SCAN_V) |=> ##1 conv_req_o && conv_kind_o == SDC_CONV_PACK) else $error("scan not started");
	a_cont_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(SDC_CMD_SCAN_CONT) |=> scan_cont_o) else $error("continuous flag not set");
	a_cont_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(SDC_CMD_SCAN_INH) |=> !scan_cont_o) else $error("continuous flag not cleared");
	a_bal_en: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(SDC_CMD_BAL_EN) |=> balance_global_enable_o) else $error("balance not enabled");
	a_ack_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(SDC_CMD_ACK) |=> rsp_kind_o == SDC_RSP_ACK && $stable(scan_cont_o)
		&& $stable(balance_global_enable_o)) else $error("ack changed state");
	a_reset_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_cmd(SDC_CMD_RESET) |=> regs_reload_o && !scan_cont_o && !balance_global_enable_o)
		else $error("reset did not stop activity");
	a_bal_nak: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		req_i && !req_wr_i && for_me && !c_reg.slp && c_reg.st == SDC_IDLE && !stand_alone_i
		&& req_page_i == SDC_PAGE_CFG && req_addr_i == SDC_OFS_BAL |=> rsp_kind_o == SDC_RSP_NAK)
		else $error("chained balance read answered");
endmodule

/* File: rtl/sdc_pkg.sv */
// Purpose: constants and types shared by the stack device command decoder
// Assumes: 14-bit register words, 6-bit register addresses, 3-bit page codes
// Notes: identification-free; nonvolatile values arrive as inputs
package sdc_pkg;
	localparam int SDC_DW = 14;
	localparam int SDC_AW = 6;
	localparam int SDC_PW = 3;
	localparam int SDC_NCELL = 12;
	localparam logic [2:0] SDC_PAGE_CFG = 3'h2;
	localparam logic [2:0] SDC_PAGE_CMD = 3'h3;
	localparam logic [2:0] SDC_PAGE_NVF = 3'h4;
	localparam logic [2:0] SDC_PAGE_NVS = 3'h5;
	localparam logic [5:0] SDC_OFS_REF_C = 6'h38;
	localparam logic [5:0] SDC_OFS_REF_B = 6'h39;
	localparam logic [5:0] SDC_OFS_REF_A = 6'h3a;
	localparam logic [5:0] SDC_OFS_BAL = 6'h3b;
	localparam logic [5:0] SDC_OFS_NVF = 6'h3f;
	localparam logic [5:0] SDC_OFS_NVS = 6'h00;
	localparam logic [5:0] SDC_CMD_SCAN_V = 6'h01;
	localparam logic [5:0] SDC_CMD_SCAN_T = 6'h02;
	localparam logic [5:0] SDC_CMD_SCAN_MIX = 6'h03;
	localparam logic [5:0] SDC_CMD_SCAN_W = 6'h04;
	localparam logic [5:0] SDC_CMD_SCAN_ALL = 6'h05;
	localparam logic [5:0] SDC_CMD_SCAN_CONT = 6'h06;
	localparam logic [5:0] SDC_CMD_SCAN_INH = 6'h07;
	localparam logic [5:0] SDC_CMD_MEASURE = 6'h08;
	localparam logic [5:0] SDC_CMD_IDENT = 6'h09;
	localparam logic [5:0] SDC_CMD_SLEEP = 6'h0a;
	localparam logic [5:0] SDC_CMD_NAK = 6'h0b;
	localparam logic [5:0] SDC_CMD_ACK = 6'h0c;
	localparam logic [5:0] SDC_CMD_COMFAIL = 6'h0e;
	localparam logic [5:0] SDC_CMD_WAKE = 6'h0f;
	localparam logic [5:0] SDC_CMD_BAL_EN = 6'h10;
	localparam logic [5:0] SDC_CMD_BAL_INH = 6'h11;
	localparam logic [5:0] SDC_CMD_RESET = 6'h12;
	localparam logic [5:0] SDC_CMD_CALC_CK = 6'h13;
	localparam logic [5:0] SDC_CMD_CHECK_CK = 6'h14;
	localparam logic [3:0] SDC_ADDR_ALL = 4'hf;
	// conversion kinds handed to the measurement engine
	localparam logic [2:0] SDC_CONV_PACK = 3'h0;
	localparam logic [2:0] SDC_CONV_CELL = 3'h1;
	localparam logic [2:0] SDC_CONV_EXT = 3'h2;
	localparam logic [2:0] SDC_CONV_DIE = 3'h3;
	localparam logic [2:0] SDC_CONV_REF = 3'h4;
	localparam logic [2:0] SDC_CONV_WIRE = 3'h5;
	localparam logic [2:0] SDC_CONV_TARGET = 3'h6;
	localparam int SDC_EXT_N = 4;
	localparam logic [3:0] SDC_MIX_EXT_AFTER = 4'h6;
	localparam logic [13:0] SDC_RST_WORD = 14'h0000;
	// link wake clock: half period in core cycles
	localparam int SDC_WAKE_HALF = 16;
	localparam int SDC_WAKE_EDGES = 8;
	typedef enum logic [1:0] {SDC_RSP_ACK, SDC_RSP_NAK, SDC_RSP_DATA, SDC_RSP_FAIL} sdc_rsp_t;
endpackage
